// ==== pmic_serial_pkg.sv ====
package pmic_serial_pkg;

  // serial frame layout
  localparam int          FRAME_BITS   = 16;
  localparam logic [4:0]  FRAME_LEN    = 5'h10;
  localparam logic [4:0]  CNT_MAX      = 5'h11;
  localparam logic [4:0]  WR_BIT_RISE  = 5'h05;
  localparam logic [3:0]  FIRST_BIT    = 4'hf;
  localparam int          ADDR_HI      = 15;
  localparam int          ADDR_LO      = 11;
  localparam int          WR_POS       = 10;
  localparam int          DATA_HI      = 8;
  localparam int          DATA_LO      = 1;
  localparam int          BANK_COUNT   = 15;
  localparam logic [4:0]  BANK_LIMIT   = 5'h0f;

  // diagnostic flag positions (also output word bits 15..9)
  localparam int          DIAG_W       = 7;
  localparam int          DG_FAULT     = 6;
  localparam int          DG_DEBOUNCE  = 5;
  localparam int          DG_SERIAL    = 4;
  localparam int          DG_BATTERY   = 3;
  localparam int          DG_WINDOW    = 2;
  localparam int          DG_QA_TMO    = 1;
  localparam int          DG_QA_ANS    = 0;
  localparam int          RAIL_W       = 5;

  // bus word addresses
  localparam logic [4:0]  ADR_DIAG     = 5'h00;
  localparam logic [4:0]  ADR_RAILS    = 5'h01;
  localparam logic [4:0]  ADR_IRQ_STAT = 5'h02;
  localparam logic [4:0]  ADR_IRQ_MASK = 5'h03;
  localparam logic [4:0]  ADR_LAST     = 5'h04;
  localparam logic [4:0]  ADR_BANK0    = 5'h10;

  // interrupt bits
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_OK       = 0;
  localparam int          IRQ_ERR      = 1;
  localparam int          IRQ_BANKWR   = 2;

  // reset values
  localparam logic [6:0]  DIAG_RST     = 7'h00;
  localparam logic [4:0]  RAILS_RST    = 5'h00;
  localparam logic [2:0]  MASK_RST     = 3'h0;

endpackage

// ==== link_if.sv ====
`timescale 1ns/10ps
interface link_if;
  logic sck_rise;
  logic sck_fall;
  logic str_low;
  logic str_fall;
  logic str_rise;
  logic sdi;

  modport sampler (output sck_rise, sck_fall, str_low, str_fall, str_rise,
                   sdi);
  modport core    (input  sck_rise, sck_fall, str_low, str_fall, str_rise,
                   sdi);
endinterface

// ==== link_sampler.sv ====
`timescale 1ns/10ps
module link_sampler (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sck_pin,
  input  wire logic sdi_pin,
  input  wire logic str_n_pin,
  link_if.sampler   lk
);
  logic [2:0] pins;
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] stable_ff;
  logic [2:0] prev_ff;

  assign pins = {str_n_pin, sdi_pin, sck_pin};

  // three stages per pin; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk) begin
        // reset to idle levels (strobe and clock high): no false edge
        if (rst) begin
          s1_ff[g]     <= (g != 1);
          s2_ff[g]     <= (g != 1);
          s3_ff[g]     <= (g != 1);
          stable_ff[g] <= (g != 1);
          prev_ff[g]   <= (g != 1);
        end else if (ce) begin
          s1_ff[g] <= pins[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin // R17
            stable_ff[g] <= s3_ff[g];
          end
          prev_ff[g] <= stable_ff[g];
        end
      end
    end
  endgenerate

  // edge detection in core domain
  assign lk.sck_rise = stable_ff[0] & ~prev_ff[0]; // R17
  assign lk.sck_fall = ~stable_ff[0] & prev_ff[0];
  assign lk.sdi      = stable_ff[1];
  assign lk.str_low  = ~stable_ff[2];
  assign lk.str_fall = ~stable_ff[2] & prev_ff[2];
  assign lk.str_rise = stable_ff[2] & ~prev_ff[2];
endmodule

// ==== pmic_serial_slave_port.sv ====
`timescale 1ns/10ps
// Contract
// (R01) Strobe high: ignore clock and data, keep shift register, output hi-z.
// (R02) Strobe low: shift data in on each rising clock, MSB first.
// (R03) Exactly 16 rising edges at strobe rise: commit word, clear diagnostics.
// (R04) Wrong edge count: drop write, keep diagnostics, set serial error.
// (R05) Strobe low: drive output MSB first, next bit per falling clock.
// (R06) Fault flag appears as first output bit as soon as strobe falls.
// (R07) Word: address 15..11, write bit 10, unused 9, data 8..1, parity 0.
// (R08) Only write bit 1 changes a register; read leaves all unchanged (a good read frame still clears diag_ff and loads last_ff).
// (R09) Write returns diagnostic flags; read returns addressed register.
// (R10) Every 16-bit word carries odd number of ones, parity in bit 0.
// (R11) Parity never stored; recomputed for every outgoing word.
// (R12) Write reply: seven flags 15..9, five rail flags 8..4, zeros, parity.
// (R13) Read reply: seven flags 15..9, register data 8..1, parity.
// (R14) Host holds clock high on strobe changes, gives 16 rising edges.
// (R15) Host keeps strobe high idle, one strobe per slave.
// (R16) Address field selects one of 15 eight-bit register banks.
// (R17) Clock and strobe synchronised into core clock, edges detected there.
module pmic_serial_slave_port
  import pmic_serial_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        SCK,
  input  wire logic        SDI,
  input  wire logic        STR_N,
  output logic             SDO,
  output logic             SDO_OE_N,
  output logic             IRQ,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST
);
  link_if lk ();

  link_sampler u_sampler (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .sck_pin   (SCK),
    .sdi_pin   (SDI),
    .str_n_pin (STR_N),
    .lk        (lk.sampler)
  );

  logic [15:0]        shift_ff;
  logic [4:0]         rise_cnt_ff;
  logic [3:0]         bit_idx_ff;
  logic               wr_ff;
  logic [4:0]         addr_ff;
  logic [DIAG_W-1:0]  snap_ff;
  logic [DIAG_W-1:0]  diag_ff;
  logic [RAIL_W-1:0]  rails_ff;
  logic [7:0]         bank_ff [BANK_COUNT];
  logic [15:0]        last_ff;
  logic [IRQ_W-1:0]   irq_stat_ff;
  logic [IRQ_W-1:0]   irq_mask_ff;
  logic               ack_ff;
  logic [31:0]        rdata_ff;
  logic               sdo_ff;
  logic               oe_n_ff;
  logic [15:0]        out_word;
  logic [7:0]         cur_bank;
  logic               frame_ok;
  logic               frame_bad;
  logic               bank_wr;
  logic               bus_acc;
  logic               bus_wr;
  logic               bus_rd;
  logic [IRQ_W-1:0]   irq_evt;
  logic [31:0]        nxt_rdata;

  // ---------------- serial framing ----------------
  assign frame_ok  = lk.str_rise & (rise_cnt_ff == FRAME_LEN); // R03
  assign frame_bad = lk.str_rise & (rise_cnt_ff != FRAME_LEN); // R04
  assign bank_wr   = frame_ok & shift_ff[WR_POS]
                     & (shift_ff[ADDR_HI:ADDR_LO] < BANK_LIMIT); // R08 R16
  assign cur_bank  = (addr_ff < BANK_LIMIT) ? bank_ff[addr_ff[3:0]] : 8'h00;

  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_ff    <= 16'h0000;
      rise_cnt_ff <= 5'h00;
    end else if (CE) begin
      if (lk.str_fall) begin
        rise_cnt_ff <= 5'h00;
      end else if (lk.str_low && lk.sck_rise) begin // R01 R02
        shift_ff <= {shift_ff[14:0], lk.sdi}; // R02
        if (rise_cnt_ff != CNT_MAX) begin
          rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
      end
    end
  end

  // write bit and address known after the sixth rising edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_ff   <= 1'b0;
      addr_ff <= 5'h00;
    end else if (CE) begin
      if (lk.str_fall) begin
        wr_ff   <= 1'b0;
        addr_ff <= 5'h00;
      end else if (lk.str_low && lk.sck_rise
                   && rise_cnt_ff == WR_BIT_RISE) begin
        wr_ff   <= lk.sdi; // R07
        addr_ff <= shift_ff[4:0]; // R07
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < BANK_COUNT; i++) begin
        bank_ff[i] <= 8'h00;
      end
      last_ff <= 16'h0000;
    end else if (CE) begin
      if (frame_ok) begin
        last_ff <= shift_ff;
      end
      if (bank_wr) begin // R03 R08
        bank_ff[shift_ff[ADDR_LO+3:ADDR_LO]] <= shift_ff[DATA_HI:DATA_LO];
      end
    end
  end

  // ---------------- outgoing word ----------------
  always_comb begin
    out_word[15:9] = snap_ff; // R12 R13
    if (wr_ff) begin
      out_word[8:1] = {rails_ff, 3'h0}; // R09 R12
    end else begin
      out_word[8:1] = cur_bank; // R09 R13
    end
    out_word[0] = ~^out_word[15:1]; // R10 R11
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      snap_ff    <= DIAG_RST;
      sdo_ff     <= 1'b0;
      oe_n_ff    <= 1'b1;
      bit_idx_ff <= FIRST_BIT;
    end else if (CE) begin
      oe_n_ff <= ~lk.str_low; // R01
      if (lk.str_fall) begin
        snap_ff    <= diag_ff;
        sdo_ff     <= diag_ff[DG_FAULT]; // R06
        bit_idx_ff <= FIRST_BIT;
      end else if (lk.str_low && lk.sck_fall && bit_idx_ff != 4'h0) begin
        sdo_ff     <= out_word[bit_idx_ff - 4'h1]; // R05
        bit_idx_ff <= bit_idx_ff - 4'h1; // R05
      end
    end
  end

  assign SDO      = sdo_ff;
  assign SDO_OE_N = oe_n_ff;

  // ---------------- bus slave ----------------
  assign bus_acc         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_acc & ~ack_ff;
  assign bus_wr          = AVS_WRITE & ack_ff & AVS_BYTEENABLE[0];
  assign bus_rd          = AVS_READ & ack_ff;
  assign AVS_READDATA    = rdata_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (AVS_ADDRESS >= ADR_BANK0) begin
      if (AVS_ADDRESS - ADR_BANK0 < BANK_LIMIT) begin
        nxt_rdata[7:0] = bank_ff[AVS_ADDRESS[3:0]];
      end
    end else begin
      case (AVS_ADDRESS)
        ADR_DIAG:     nxt_rdata[DIAG_W-1:0] = diag_ff;
        ADR_RAILS:    nxt_rdata[RAIL_W-1:0] = rails_ff;
        ADR_IRQ_STAT: nxt_rdata[IRQ_W-1:0]  = irq_stat_ff;
        ADR_IRQ_MASK: nxt_rdata[IRQ_W-1:0]  = irq_mask_ff;
        ADR_LAST:     nxt_rdata[15:0]       = last_ff;
        default:      nxt_rdata             = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (CE) begin
      ack_ff <= bus_acc & ~ack_ff;
      if (AVS_READ && !ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // diagnostics: frame hardware has priority over software writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      diag_ff     <= DIAG_RST;
      rails_ff    <= RAILS_RST;
      irq_mask_ff <= MASK_RST;
    end else if (CE) begin
      if (frame_ok) begin
        diag_ff <= DIAG_RST; // R03
      end else if (frame_bad) begin
        diag_ff[DG_SERIAL] <= 1'b1; // R04
      end else if (bus_wr && AVS_ADDRESS == ADR_DIAG) begin
        diag_ff <= AVS_WRITEDATA[DIAG_W-1:0];
      end
      if (bus_wr && AVS_ADDRESS == ADR_RAILS) begin
        rails_ff <= AVS_WRITEDATA[RAIL_W-1:0];
      end
      if (bus_wr && AVS_ADDRESS == ADR_IRQ_MASK) begin
        irq_mask_ff <= AVS_WRITEDATA[IRQ_W-1:0];
      end
    end
  end

  // sticky events; a read clears only the bits it returned
  assign irq_evt = {bank_wr, frame_bad, frame_ok};

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat_ff <= 3'h0;
    end else if (CE) begin
      if (bus_rd && AVS_ADDRESS == ADR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~rdata_ff[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
    end
  end

  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || !CE);

  AST_HIZ_AFTER_RISE: assert property ( // R01
    lk.str_rise ##1 CE |-> SDO_OE_N)
    else $error("output not released after strobe rise");

  AST_SHIFT_IN: assert property ( // R02
    lk.str_low && lk.sck_rise && !lk.str_fall |=>
      shift_ff[0] == $past(lk.sdi) && shift_ff[15:1] == $past(shift_ff[14:0]))
    else $error("serial input not shifted");

  AST_COMMIT: assert property ( // R03
    bank_wr |=> bank_ff[$past(shift_ff[ADDR_LO+3:ADDR_LO])]
                == $past(shift_ff[DATA_HI:DATA_LO]) && diag_ff == DIAG_RST)
    else $error("good frame not committed");

  AST_ERR_FLAG: assert property ( // R04
    frame_bad |=> diag_ff[DG_SERIAL] && $stable(last_ff))
    else $error("bad frame not flagged");

  AST_ADVANCE: assert property ( // R05
    lk.str_low && lk.sck_fall && !lk.str_fall && bit_idx_ff != 4'h0 |=>
      bit_idx_ff == $past(bit_idx_ff) - 4'h1)
    else $error("output bit did not advance");

  AST_FAULT_FIRST: assert property ( // R06
    lk.str_fall |=> SDO == $past(diag_ff[DG_FAULT]) && !SDO_OE_N)
    else $error("fault flag not first");

  AST_READ_NO_WRITE: assert property ( // R08
    frame_ok && !shift_ff[WR_POS] |=> $stable(cur_bank))
    else $error("read changed a register");

  AST_ODD_PARITY: assert property ( // R10
    lk.str_low |-> ^out_word)
    else $error("outgoing word not odd parity");

  AST_WRITE_REPLY: assert property ( // R12
    lk.str_low && wr_ff |-> out_word[3:1] == 3'h0
                           && out_word[8:4] == rails_ff)
    else $error("write reply layout wrong");

  AST_HIZ_IDLE: assert property ( // R01
    !lk.str_low |=> SDO_OE_N)
    else $error("output driven while strobe high");

  AST_IDLE_HOLD: assert property ( // R01
    !lk.str_low |=> $stable(shift_ff) && $stable(rise_cnt_ff))
    else $error("shift register moved while strobe high");

  AST_ERR_STICKY: assert property ( // R04
    frame_bad |=> irq_stat_ff[IRQ_ERR])
    else $error("bad frame event lost");

  COV_WRITE: cover property (bank_wr);
  COV_READ:  cover property (frame_ok && !shift_ff[WR_POS]);
  COV_ERROR: cover property (frame_bad);
  COV_IRQ:   cover property (IRQ);
endmodule

// ==== host_link_model.sv ====
`timescale 1ns/10ps
module host_link_model (
  output logic      sck,
  output logic      sdi,
  output logic      str_n,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  localparam realtime HALF = 62.5;
  logic last;

  initial begin
    sck = 1'b1;
    sdi = 1'b0;
    str_n = 1'b1;
    last = 1'b0;
  end

  // sample before each fall; released line reads as inverse of last
  task automatic frame(input logic [15:0] w, input int edges,
                       output logic [15:0] rep);
    int i;
    rep = '0;
    str_n = 1'b0;
    #(2*HALF);
    for (i = 0; i < edges; i++) begin
      if (i < 16) begin
        last = sdo_oe_n ? ~last : sdo;
        rep[15-i] = last;
      end
      sck = 1'b0;
      sdi = (i < 16) ? w[15-i] : 1'b0;
      #HALF;
      sck = 1'b1;
      #HALF;
    end
    str_n = 1'b1;
    sdi = 1'b0;
    #(4*HALF);
  endtask

  // clock and data activity with strobe idle
  task automatic noise();
    int i;
    for (i = 0; i < 4; i++) begin
      #HALF;
      sck = 1'b0;
      sdi = ~sdi;
      #HALF;
      sck = 1'b1;
    end
    sdi = 1'b0;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import pmic_serial_pkg::*;
  logic        clk, rst, sck, sdi, str_n, sdo, sdo_oe_n, irq, wreq;
  logic        rd, wr, ce;
  logic [4:0]  adr, ba;
  logic [31:0] wdat, rdat, seed, got;
  logic [3:0]  be;
  logic [15:0] rep;
  logic [6:0]  dg;
  logic [4:0]  rl;
  logic [7:0]  bd;
  int          bad_count, checked, cyc, e;

  pmic_serial_slave_port u_pmic_serial_slave_port (
    .CLK(clk), .RST(rst), .CE(ce), .SCK(sck), .SDI(sdi), .STR_N(str_n),
    .SDO(sdo), .SDO_OE_N(sdo_oe_n), .IRQ(irq), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq));

  host_link_model u_host_link_model (
    .sck(sck), .sdi(sdi), .str_n(str_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] odd(input logic [14:0] h);
    return {h, ~^h};
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] g, x, input string m);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic chk_reg(input logic [31:0] g, x, input string m);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] x,
                       input string m);
    bus(1'b0, a, 32'h0, got);
    chk_reg(got, x, m);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    adr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    be = 4'hf;
    ce = 1'b1;
    seed = 32'hbc33;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk_reg({31'h0, irq}, 32'h0, "irq idle");
    chk_reg({31'h0, sdo_oe_n}, 32'h1, "out idle");
    rdchk(5'h08, 32'h0, "unmapped");
    rdchk(ADR_IRQ_MASK, 32'h0, "mask");
    bus(1'b1, ADR_IRQ_MASK, 32'h7, got);
    repeat (4) begin
      dg = 7'(rnd());
      rl = 5'(rnd());
      ba = 5'(rnd() % 15);
      bd = 8'(rnd());
      bus(1'b1, ADR_DIAG, {25'h0, dg}, got);
      bus(1'b1, ADR_RAILS, {27'h0, rl}, got);
      u_host_link_model.frame(odd({ba, 2'b10, bd}), 16, rep);
      chk_word(rep, odd({dg, rl, 3'h0}), "write reply");
      chk_reg({31'h0, irq}, 32'h1, "irq up");
      rdchk(ADR_DIAG, 32'h0, "diag clear");
      rdchk(ADR_IRQ_STAT, 32'h5, "stat");
      @(posedge clk);
      chk_reg({31'h0, irq}, 32'h0, "irq down");
      rdchk(ADR_BANK0 + ba, {24'h0, bd}, "bank");
      u_host_link_model.frame(odd({ba, 2'b00, ~bd}), 16, rep);
      chk_word(rep, odd({7'h0, bd}), "read reply");
      rdchk(ADR_BANK0 + ba, {24'h0, bd}, "bank kept");
      rdchk(ADR_IRQ_STAT, 32'h1, "read stat");
    end
    for (e = 15; e <= 17; e += 2) begin
      dg = (7'(rnd()) & 7'h6f) | 7'h40;
      bus(1'b1, ADR_DIAG, {25'h0, dg}, got);
      u_host_link_model.frame(odd({ba, 2'b10, ~bd}), e, rep);
      chk_word({15'h0, rep[15]}, {15'h0, dg[6]}, "first");
      rdchk(ADR_DIAG, {25'h0, dg | 7'h10}, "serr");
      rdchk(ADR_BANK0 + ba, {24'h0, bd}, "dropped");
      rdchk(ADR_IRQ_STAT, 32'h2, "bad stat");
    end
    u_host_link_model.noise();
    chk_reg({31'h0, sdo_oe_n}, 32'h1, "noise");
    bus(1'b1, ADR_DIAG, 32'h40, got);
    be <= 4'h0;
    bus(1'b1, ADR_DIAG, 32'h0, got);
    be <= 4'hf;
    rdchk(ADR_DIAG, 32'h40, "byteenable");
    u_host_link_model.frame(odd({5'h0f, 2'b10, 8'ha5}), 16, rep);
    chk_word({15'h0, rep[15]}, 16'h1, "fault");
    rdchk(ADR_IRQ_STAT, 32'h1, "addr 15");
    bus(1'b1, ADR_IRQ_MASK, 32'h2, got);
    u_host_link_model.frame(odd({ba, 2'b00, 8'h00}), 16, rep);
    chk_reg({31'h0, irq}, 32'h0, "masked");
    rdchk(ADR_IRQ_STAT, 32'h1, "masked stat");
    ce <= 1'b0;
    @(posedge clk);
    u_host_link_model.frame(odd({ba, 2'b10, ~bd}), 16, rep);
    @(posedge clk);
    ce <= 1'b1;
    rdchk(ADR_IRQ_STAT, 32'h0, "frozen stat");
    rdchk(ADR_BANK0 + ba, {24'h0, bd}, "frozen bank");
    test_done();
  end
endmodule
